// *** rtl/pic_op_consts.vh ***
// named constants for the interrupt controller operating logic
`ifndef PIC_OP_CONSTS_VH
`define PIC_OP_CONSTS_VH

// ----------------------------------------------------------------
// register addressing on the byte port
// ----------------------------------------------------------------
`define ADDR_CMD 1'b0
`define ADDR_MASK 1'b1

// ----------------------------------------------------------------
// command word decode, even address
// ----------------------------------------------------------------
`define CMD_INIT_BIT 4
`define CMD_MODE_BIT 3
`define PRI_OP_HI 7
`define PRI_OP_LO 5
`define LEVEL_HI 2
`define LEVEL_LO 0

// rotate, level select, service done
`define OP_CLR_ROT_AUTO_SERVICE_DONE 3'h0
`define OP_EOI 3'h1
`define OP_NOP 3'h2
`define OP_SEOI 3'h3
`define OP_SET_ROT_AUTO_SERVICE_DONE 3'h4
`define OP_ROT_EOI 3'h5
`define OP_SET_PRIO 3'h6
`define OP_ROT_SEOI 3'h7

// mode read word fields
`define SPECIAL_MASK_WRITE_ENABLE_BIT 6
`define SMM_BIT 5
`define POLL_BIT 2
`define RR_BIT 1
`define RIS_BIT 0

// poll answer
`define POLL_FLAG_BIT 7

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_MASK 8'h00
`define RST_LOWEST 3'h7
`define DEFAULT_LEVEL 3'h7
`define LAST_ACK_TWO 2'h2
`define LAST_ACK_THREE 2'h3
`define PIN_WIDTH 23
`define PIN_RST 23'h78_0000

`endif

// *** rtl/pin_sync.v ***
// two stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 23,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [W-1:0] pins,
  output reg [W-1:0] pins_s
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RST;
      pins_s <= RST;
    end else begin
      meta_q <= pins;
      pins_s <= meta_q;
    end
  end
endmodule // pin_sync

// *** rtl/prio_find.v ***
// rotating priority finder: highest ranked set bit
`timescale 1ns/1ps
module prio_find (
  input wire [7:0] bits,
  input wire [2:0] lowest,
  output reg found,
  output reg [2:0] level,
  output reg [2:0] rank
);
  integer k;
  reg [2:0] idx;

  // rank 0 is the level just above the lowest one
  always @* begin
    found = 1'b0;
    level = 3'h0;
    rank = 3'h0;
    idx = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      idx = lowest + 3'h1 + k[2:0];
      if (bits[idx]) begin
        found = 1'b1;
        level = idx;
        rank = k[2:0];
      end
    end
  end
endmodule // prio_find

// *** rtl/pic_operation.v ***
// operating logic of an eight input priority interrupt controller
//
// Behaviour
// - odd address write loads all mask bits
// - each mask bit inhibits only its input
// - level field used only with level select
// - fully nested after reset, level 0 highest
// - acknowledge resolves winner and sets in-service
// - in-service blocks equal and lower levels
// - non-specific done clears highest in-service bit
// - specific done clears the named in-service bit
// - auto done at last acknowledge trailing edge
// - special mask: masked levels skip non-specific done
// - auto rotation makes serviced level lowest
// - rotate on non-specific done
// - set and clear rotate in auto done
// - set priority keeps in-service bits
// - rotate on specific done
// - special mask enter, leave or keep
// - special mask: only mask bits block
// - poll turns next even address read into acknowledge
// - requests frozen from poll write to read
// - poll answer: flag bit 7, level bits 2-0
// - readback select kept until changed
// - odd read gives mask, poll beats status
`timescale 1ns/1ps
`include "pic_op_consts.vh"
module pic_operation #(
  parameter [4:0] VECTOR_BASE = 5'h00
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire address_bit_low,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  input wire acknowledge_strobe_n,
  input wire [7:0] request_input,
  input wire auto_service_done,
  input wire two_pulse_mode,
  output reg interrupt_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [7:0] level_bit;
    input [2:0] lvl;
    begin
      level_bit = 8'h01 << lvl;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  wire [`PIN_WIDTH-1:0] pins_s;
  wire cs_n_s;
  wire rd_n_s;
  wire wr_n_s;
  wire ack_n_s;
  wire a0_s;
  wire auto_service_done_s;
  wire two_s;
  wire [7:0] data_s;
  wire [7:0] req_s;

  pin_sync #(
    .W(`PIN_WIDTH),
    .RST(`PIN_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pins({chip_select_n, read_strobe_n, write_strobe_n,
      acknowledge_strobe_n, address_bit_low, auto_service_done,
      two_pulse_mode, data_in, request_input}),
    .pins_s(pins_s)
  );

  assign cs_n_s = pins_s[22];
  assign rd_n_s = pins_s[21];
  assign wr_n_s = pins_s[20];
  assign ack_n_s = pins_s[19];
  assign a0_s = pins_s[18];
  assign auto_service_done_s = pins_s[17];
  assign two_s = pins_s[16];
  assign data_s = pins_s[15:8];
  assign req_s = pins_s[7:0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg rd_n_p_q;
  reg wr_n_p_q;
  reg ack_n_p_q;
  reg cs_n_p_q;
  reg [7:0] mask_reg_q;
  reg [7:0] mask_reg_d;
  reg [7:0] pending_q;
  reg [7:0] in_service_q;
  reg [7:0] in_service_d;
  reg [2:0] lowest_q;
  reg [2:0] lowest_d;
  reg special_mask_q;
  reg special_mask_d;
  reg readback_select_q;
  reg readback_select_d;
  reg poll_q;
  reg poll_d;
  reg rot_auto_service_done_q;
  reg rot_auto_service_done_d;
  reg freeze_q;
  reg freeze_d;
  reg [1:0] ack_count_q;
  reg [1:0] ack_count_d;
  reg [2:0] ack_level_q;
  reg [2:0] ack_level_d;
  reg [7:0] data_out_d;
  reg data_oe_d;

  // ----------------------------------------------------------------
  // strobe edges
  // ----------------------------------------------------------------
  wire wr_done;
  wire rd_start;
  wire rd_active;
  wire ack_fall;
  wire ack_rise;
  wire [1:0] last_ack;

  // write data taken at the trailing edge, while still selected
  assign wr_done = ~wr_n_p_q & wr_n_s & ~cs_n_p_q;
  assign rd_start = rd_n_p_q & ~rd_n_s & ~cs_n_s;
  assign rd_active = ~rd_n_s & ~cs_n_s;
  assign ack_fall = ack_n_p_q & ~ack_n_s;
  assign ack_rise = ~ack_n_p_q & ack_n_s;
  assign last_ack = two_s ? `LAST_ACK_TWO : `LAST_ACK_THREE;

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  wire [7:0] candidates;
  wire [7:0] service_view;
  wire req_found;
  wire [2:0] req_level;
  wire [2:0] req_rank;
  wire isr_found;
  wire [2:0] isr_level;
  wire [2:0] isr_rank;
  wire int_cond;
  wire [2:0] win_level;

  assign candidates = pending_q & ~mask_reg_q;
  // in special mask mode masked in-service levels are hidden
  assign service_view = special_mask_q ?
    (in_service_q & ~mask_reg_q) : in_service_q;

  prio_find u_req (
    .bits(candidates),
    .lowest(lowest_q),
    .found(req_found),
    .level(req_level),
    .rank(req_rank)
  );

  prio_find u_isr (
    .bits(service_view),
    .lowest(lowest_q),
    .found(isr_found),
    .level(isr_level),
    .rank(isr_rank)
  );

  // outside special mask mode only a strictly higher rank gets past an in-service level
  assign int_cond = req_found & (special_mask_q | ~isr_found |
    (req_rank < isr_rank));
  // no winner at acknowledge: default highest-numbered vector, level 7
  assign win_level = int_cond ? req_level : `DEFAULT_LEVEL;

  // ----------------------------------------------------------------
  // command decode and sequencing
  // ----------------------------------------------------------------
  wire [2:0] op;
  wire [2:0] op_level;
  wire is_mode_word;
  wire is_init_word;

  assign op = data_s[`PRI_OP_HI:`PRI_OP_LO];
  assign op_level = data_s[`LEVEL_HI:`LEVEL_LO];
  assign is_mode_word = data_s[`CMD_MODE_BIT];
  assign is_init_word = data_s[`CMD_INIT_BIT];

  always @* begin
    mask_reg_d = mask_reg_q;
    in_service_d = in_service_q;
    lowest_d = lowest_q;
    special_mask_d = special_mask_q;
    readback_select_d = readback_select_q;
    poll_d = poll_q;
    rot_auto_service_done_d = rot_auto_service_done_q;
    freeze_d = freeze_q;
    ack_count_d = ack_count_q;
    ack_level_d = ack_level_q;

    // host writes
    if (wr_done) begin
      if (a0_s == `ADDR_MASK) begin
        mask_reg_d = data_s;
      end else if (is_init_word) begin
        // initialisation sequence is handled elsewhere
        mask_reg_d = mask_reg_q;
      end else if (is_mode_word) begin
        if (data_s[`SPECIAL_MASK_WRITE_ENABLE_BIT]) begin
          special_mask_d = data_s[`SMM_BIT];
        end
        if (data_s[`RR_BIT]) begin
          readback_select_d = data_s[`RIS_BIT];
        end
        if (data_s[`POLL_BIT]) begin
          poll_d = 1'b1;
          freeze_d = 1'b1;
        end
      end else begin
        case (op)
          `OP_EOI: begin
            if (isr_found) begin
              in_service_d = in_service_q &
                ~level_bit(isr_level);
            end
          end
          `OP_SEOI: begin
            in_service_d = in_service_q &
              ~level_bit(op_level);
          end
          `OP_ROT_EOI: begin
            if (isr_found) begin
              in_service_d = in_service_q &
                ~level_bit(isr_level);
              lowest_d = isr_level;
            end
          end
          `OP_SET_ROT_AUTO_SERVICE_DONE: begin
            rot_auto_service_done_d = 1'b1;
          end
          `OP_CLR_ROT_AUTO_SERVICE_DONE: begin
            rot_auto_service_done_d = 1'b0;
          end
          `OP_SET_PRIO: begin
            lowest_d = op_level;
          end
          `OP_ROT_SEOI: begin
            in_service_d = in_service_q &
              ~level_bit(op_level);
            lowest_d = op_level;
          end
          `OP_NOP: begin
            lowest_d = lowest_q;
          end
          default: begin
            lowest_d = lowest_q;
          end
        endcase
      end
    end

    // poll read acts as an acknowledge
    if (rd_start && poll_q && a0_s == `ADDR_CMD) begin
      if (int_cond) begin
        in_service_d = in_service_d | level_bit(req_level);
      end
      poll_d = 1'b0;
      freeze_d = 1'b0;
    end

    // acknowledge pulse sequence
    if (ack_fall) begin
      ack_count_d = ack_count_q + 2'h1;
      if (ack_count_q == 2'h0) begin
        freeze_d = 1'b1;
        ack_level_d = win_level;
        if (int_cond) begin
          in_service_d = in_service_d | level_bit(req_level);
        end
      end
    end else if (ack_rise && ack_count_q == last_ack) begin
      ack_count_d = 2'h0;
      freeze_d = 1'b0;
      if (auto_service_done_s && isr_found) begin
        in_service_d = in_service_d &
          ~level_bit(isr_level);
        if (rot_auto_service_done_q) begin
          lowest_d = isr_level;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  // read byte latched at the start so a poll answer cannot shift
  always @* begin
    data_out_d = data_out;
    data_oe_d = 1'b0;
    if (rd_start) begin
      if (a0_s == `ADDR_MASK) begin
        data_out_d = mask_reg_q;
      end else if (poll_q) begin
        data_out_d = 8'h00;
        data_out_d[`POLL_FLAG_BIT] = int_cond;
        data_out_d[`LEVEL_HI:`LEVEL_LO] = req_level;
      end else if (readback_select_q) begin
        data_out_d = in_service_q;
      end else begin
        data_out_d = pending_q;
      end
    end
    if (rd_active) begin
      data_oe_d = 1'b1;
    end
    // vector byte on the last acknowledge pulse
    if (~ack_n_s && ack_count_q == last_ack) begin
      data_out_d = {VECTOR_BASE, ack_level_q};
      data_oe_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_n_p_q <= 1'b1;
      wr_n_p_q <= 1'b1;
      ack_n_p_q <= 1'b1;
      cs_n_p_q <= 1'b1;
      mask_reg_q <= `RST_MASK;
      pending_q <= 8'h00;
      in_service_q <= 8'h00;
      lowest_q <= `RST_LOWEST;
      special_mask_q <= 1'b0;
      readback_select_q <= 1'b0;
      poll_q <= 1'b0;
      rot_auto_service_done_q <= 1'b0;
      freeze_q <= 1'b0;
      ack_count_q <= 2'h0;
      ack_level_q <= 3'h0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      interrupt_out <= 1'b0;
    end else begin
      rd_n_p_q <= rd_n_s;
      wr_n_p_q <= wr_n_s;
      ack_n_p_q <= ack_n_s;
      cs_n_p_q <= cs_n_s;
      mask_reg_q <= mask_reg_d;
      // frozen requests keep the resolved level stable
      if (!freeze_q) begin
        pending_q <= req_s;
      end
      in_service_q <= in_service_d;
      lowest_q <= lowest_d;
      special_mask_q <= special_mask_d;
      readback_select_q <= readback_select_d;
      poll_q <= poll_d;
      rot_auto_service_done_q <= rot_auto_service_done_d;
      freeze_q <= freeze_d;
      ack_count_q <= ack_count_d;
      ack_level_q <= ack_level_d;
      data_out <= data_out_d;
      data_oe <= data_oe_d;
      interrupt_out <= int_cond;
    end
  end

endmodule // pic_operation

// *** testbench/pic_operation_monitor.sv ***
// port checker for the interrupt controller operating logic
`timescale 1ns/1ps
module pic_operation_monitor #(
  parameter [4:0] VECTOR_BASE = 5'h00
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire address_bit_low,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire data_oe,
  input wire acknowledge_strobe_n,
  input wire [7:0] request_input,
  input wire auto_service_done,
  input wire two_pulse_mode,
  input wire interrupt_out
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  reg rd_q, wr_q, ak_q, poll_q;
  reg [1:0] src_q, ak_cnt_q;
  reg [7:0] mask_q;
  wire last_ack = ak_cnt_q == (two_pulse_mode ? 2'h1 : 2'h2);
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      ak_q <= 1'b1;
      poll_q <= 1'b0;
      src_q <= 2'h0;
      ak_cnt_q <= 2'h0;
      mask_q <= 8'h00;
    end else begin
      rd_q <= read_strobe_n;
      wr_q <= write_strobe_n;
      ak_q <= acknowledge_strobe_n;
      if (!wr_q && write_strobe_n && !chip_select_n) begin
        if (address_bit_low)
          mask_q <= data_in;
        else if (data_in[4:3] == 2'h1)
          poll_q <= data_in[2];
      end
      if (rd_q && !read_strobe_n && !chip_select_n) begin
        src_q <= address_bit_low ? 2'h1 : (poll_q ? 2'h2 : 2'h3);
        poll_q <= 1'b0;
      end
      // an acknowledge owns the bus until its vector is gone
      if (ak_q && !acknowledge_strobe_n) begin
        src_q <= 2'h0;
        ak_cnt_q <= last_ack ? 2'h0 : ak_cnt_q + 2'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_go;
    $fell(read_strobe_n) && !chip_select_n;
  endsequence
  sequence strobe_end;
    $rose(read_strobe_n) || $rose(acknowledge_strobe_n);
  endsequence
  a_oe_timely: assert property (rd_go |-> ##[2:6] data_oe)
    else $error("read not answered in time");
  a_vec_timely: assert property ($fell(acknowledge_strobe_n) && last_ack |-> ##[2:6] data_oe)
    else $error("vector not driven on last pulse");
  a_early_quiet: assert property ($fell(acknowledge_strobe_n) && !last_ack |-> ##1 !data_oe [*4])
    else $error("bus driven on early pulse");
  a_oe_release: assert property (strobe_end |-> ##[1:6] !data_oe)
    else $error("bus not released");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !data_oe && !interrupt_out)
    else $error("outputs active after reset");
  a_vector_base: assert property (data_oe && src_q == 2'h0 |-> data_out[7:3] == VECTOR_BASE)
    else $error("vector base wrong");
  a_hold_data: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("read data moved");
  a_mask_read: assert property (data_oe && src_q == 2'h1 |-> data_out == mask_q)
    else $error("mask readback wrong");
  a_poll_format: assert property (data_oe && src_q == 2'h2 |-> data_out[6:3] == 4'h0)
    else $error("poll byte format wrong");
endmodule // pic_operation_monitor

bind pic_operation pic_operation_monitor #(.VECTOR_BASE(VECTOR_BASE)) mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .address_bit_low(address_bit_low), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe),
  .acknowledge_strobe_n(acknowledge_strobe_n),
  .request_input(request_input), .auto_service_done(auto_service_done),
  .two_pulse_mode(two_pulse_mode), .interrupt_out(interrupt_out));

// *** testbench/host_bus.sv ***
// host processor model driving the byte port and acknowledge pulses
`timescale 1ns/1ps
module host_bus (
  input wire sys_clk,
  input wire [7:0] data_out,
  output reg chip_select_n,
  output reg read_strobe_n,
  output reg write_strobe_n,
  output reg address_bit_low,
  output reg [7:0] data_in,
  output reg acknowledge_strobe_n
);
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    address_bit_low = 1'b0;
    data_in = 8'h5a;
    acknowledge_strobe_n = 1'b1;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  // strobes held 6 clocks so the synchronised edges are never missed
  task wr(input a, input [7:0] d);
    begin
      chip_select_n = 1'b0;
      address_bit_low = a;
      data_in = d;
      write_strobe_n = 1'b0;
      tick(6);
      write_strobe_n = 1'b1;
      tick(5);
      chip_select_n = 1'b1;
      // released bus: inverse value, never a stale copy
      data_in = ~d;
      // one edge deselected so back to back calls never merge
      tick(1);
    end
  endtask
  task rd(input a, output [7:0] v);
    begin
      chip_select_n = 1'b0;
      address_bit_low = a;
      read_strobe_n = 1'b0;
      tick(6);
      v = data_out;
      read_strobe_n = 1'b1;
      tick(5);
      chip_select_n = 1'b1;
      tick(1);
    end
  endtask
  task ack(input integer n, output [7:0] v);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        acknowledge_strobe_n = 1'b0;
        tick(6);
        v = data_out;
        acknowledge_strobe_n = 1'b1;
        tick(6);
      end
    end
  endtask
endmodule // host_bus

// *** testbench/pic_operation_test.sv ***
// self-checking bench for the interrupt controller operating logic
`timescale 1ns/1ps
module pic_operation_test;
  reg sys_clk, sys_rst, auto_service_done, two_pulse_mode;
  reg [7:0] request_input, v;
  wire chip_select_n, read_strobe_n, write_strobe_n, address_bit_low;
  wire acknowledge_strobe_n, data_oe, interrupt_out;
  wire [7:0] data_in, data_out;
  integer error_cnt, checked, cycles, tn;
  pic_operation #(.VECTOR_BASE(5'h15)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .address_bit_low(address_bit_low), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe),
    .acknowledge_strobe_n(acknowledge_strobe_n),
    .request_input(request_input), .auto_service_done(auto_service_done),
    .two_pulse_mode(two_pulse_mode), .interrupt_out(interrupt_out));
  host_bus h (
    .sys_clk(sys_clk), .data_out(data_out), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .address_bit_low(address_bit_low), .data_in(data_in),
    .acknowledge_strobe_n(acknowledge_strobe_n));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task r(input a, input [7:0] e);
    begin
      h.rd(a, v);
      chk(v, e);
    end
  endtask
  task k(input integer n, input [7:0] e);
    begin
      // host acknowledges only once the request has been seen
      h.tick(4);
      h.ack(n, v);
      chk(v, e);
    end
  endtask
  task ci(input e);
    begin
      h.tick(10);
      chk({7'h00, interrupt_out}, {7'h00, e});
    end
  endtask
  task te;
    begin
      $display("test %0d done", tn);
      tn = tn + 1;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ceiling well above the roughly one thousand cycles the tests need
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    tn = 1;
    sys_rst = 1'b1;
    request_input = 8'h00;
    auto_service_done = 1'b0;
    two_pulse_mode = 1'b1;
    h.tick(8);
    sys_rst = 1'b0;
    h.tick(4);
    r(1, 8'h00);
    w_and_r: begin
      h.wr(1, 8'hfb);
      r(1, 8'hfb);
    end
    request_input = 8'h04;
    ci(1'b1);
    h.wr(1, 8'h04);
    ci(1'b0);
    r(0, 8'h04);
    h.wr(1, 8'h00);
    te;
    request_input = 8'h88;
    k(2, 8'hab);
    h.wr(0, 8'h0b);
    r(0, 8'h08);
    ci(1'b0);
    request_input = 8'h8a;
    ci(1'b1);
    k(2, 8'ha9);
    h.wr(0, 8'h27);
    r(0, 8'h08);
    h.wr(0, 8'h43);
    r(0, 8'h08);
    h.wr(0, 8'h63);
    r(0, 8'h00);
    te;
    request_input = 8'h88;
    h.wr(0, 8'h0f);
    request_input = 8'h00;
    h.tick(10);
    r(0, 8'h83);
    r(0, 8'h08);
    h.wr(0, 8'h20);
    te;
    request_input = 8'h21;
    h.wr(0, 8'hc4);
    k(2, 8'had);
    h.wr(0, 8'ha0);
    k(2, 8'ha8);
    h.wr(0, 8'he0);
    r(0, 8'h00);
    k(2, 8'had);
    h.wr(0, 8'hc2);
    r(0, 8'h20);
    h.wr(0, 8'h65);
    h.wr(0, 8'hc7);
    te;
    auto_service_done = 1'b1;
    two_pulse_mode = 1'b0;
    request_input = 8'h01;
    k(3, 8'ha8);
    r(0, 8'h00);
    h.wr(0, 8'h80);
    request_input = 8'h03;
    k(3, 8'ha8);
    k(3, 8'ha9);
    r(0, 8'h00);
    h.wr(0, 8'h00);
    k(3, 8'ha8);
    k(3, 8'ha8);
    h.wr(0, 8'hc7);
    auto_service_done = 1'b0;
    two_pulse_mode = 1'b1;
    te;
    request_input = 8'h01;
    k(2, 8'ha8);
    request_input = 8'h04;
    ci(1'b0);
    h.wr(0, 8'h68);
    ci(1'b1);
    h.wr(0, 8'h28);
    ci(1'b1);
    h.wr(1, 8'h01);
    h.wr(0, 8'h20);
    r(0, 8'h01);
    h.wr(0, 8'h48);
    ci(1'b0);
    h.wr(0, 8'h60);
    h.wr(1, 8'h00);
    h.wr(0, 8'h0a);
    r(0, 8'h04);
    request_input = 8'h00;
    k(2, 8'haf);
    h.wr(0, 8'h0b);
    r(0, 8'h00);
    te;
    print_verdict;
  end
endmodule // pic_operation_test
